// ===== fpm_flash_pin_ctrl.v
`timescale 1ns/100ps
`include "fpm_regs.vh"
// Operation
// - Low-order address captured internally on every write cycle.
// - Data byte latched internally during each write cycle.
// - Data pins released while output enable high; drive read data when it is low in parallel mode out of reset.
// - Output enable gates drivers; falling write enable starts writes only while output enable is high.
// - Configuration high selects parallel mode, low selects hub mode.
// - Low on initialize or reset gives internal reset in hub mode; only reset counts in parallel mode.
// - Four strap inputs give the device identity on the shared bus.
// - Top block lock low refuses program and erase of boot block.
// - Write protect low refuses program of all lower blocks.
module fpm_flash_pin_ctrl #(
    parameter AW = `FPM_ADDR_AW,
    parameter PW = `FPM_PIN_AW,
    parameter DW = `FPM_DATA_W
) (
    input wire ref_clk_i,
    input wire rst_b_i,
    input wire interface_config_select_i,
    input wire init_n_i,
    input wire reset_n_i,
    input wire [3:0] strap_identity_inputs_i,
    input wire [3:0] hub_target_id_i,
    input wire top_block_lock_n_i,
    input wire write_protect_n_i,
    input wire row_col_sel_i,
    input wire output_enable_n_i,
    input wire write_enable_n_i,
    input wire [PW-1:0] muxed_address_pins_i,
    input wire [DW-1:0] parallel_data_pins_i,
    input wire [DW-1:0] read_data_i,
    input wire [AW-1:0] hub_addr_i,
    input wire hub_write_req_i,
    output reg [DW-1:0] parallel_data_pins_o,
    output reg parallel_data_pins_oe_o,
    output reg parallel_program_mode_o,
    output reg hub_serial_mode_o,
    output reg int_reset_n_o,
    output reg id_match_o,
    output reg [AW-1:0] latched_addr_o,
    output reg [DW-1:0] latched_data_o,
    output reg write_start_o,
    output reg write_refused_o
);
    localparam SW = PW + DW + 8;
    wire [SW-1:0] sync_in;
    wire [SW-1:0] sync_out;
    wire [PW-1:0] addr_s;
    wire [DW-1:0] data_s;
    wire cfg_s;
    wire init_s;
    wire rstn_s;
    wire tbl_s;
    wire wp_s;
    wire rc_s;
    wire oe_s;
    wire we_s;
    wire rst_lvl_s;
    wire write_go;
    reg we_prev_reg;
    reg cfg_reg;
    reg cfg_valid_reg;
    reg [PW-1:0] row_reg;
    reg [PW-1:0] col_reg;
    reg [AW-1:0] wr_addr;
    reg [`FPM_BLOCK_W-1:0] blk;
    reg protect;
    reg wr_fire;

    // Pin levels packed for the synchroniser, address on top
    assign sync_in[SW-1:DW+8] = muxed_address_pins_i;
    assign sync_in[DW+7:8] = parallel_data_pins_i;
    assign sync_in[7] = interface_config_select_i;
    assign sync_in[6] = init_n_i;
    assign sync_in[5] = reset_n_i;
    assign sync_in[4] = top_block_lock_n_i;
    assign sync_in[3] = write_protect_n_i;
    assign sync_in[2] = row_col_sel_i;
    assign sync_in[1] = output_enable_n_i;
    assign sync_in[0] = write_enable_n_i;

    // Packed pin levels pass two flops before use; strap, hub and read data inputs do not
    fpm_sync #(.W(SW)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(sync_in),
        .q_o(sync_out)
    );

    // Synchronised levels unpacked in the same order as packed
    assign addr_s = sync_out[SW-1:DW+8];
    assign data_s = sync_out[DW+7:8];
    assign cfg_s = sync_out[7];
    assign init_s = sync_out[6];
    assign rstn_s = sync_out[5];
    assign tbl_s = sync_out[4];
    assign wp_s = sync_out[3];
    assign rc_s = sync_out[2];
    assign oe_s = sync_out[1];
    assign we_s = sync_out[0];

    // Both reset inputs seen together; the synchroniser resets low,
    // so internal reset also stands while the first real levels arrive
    assign rst_lvl_s = init_s && rstn_s;

    // A write is only taken while internal reset is released
    assign write_go = wr_fire && int_reset_n_o;

    // Write target: assembled halves in parallel mode, hub address otherwise
    always @* begin
        if (cfg_reg)
            wr_addr = {row_reg, col_reg};
        else
            wr_addr = hub_addr_i;
        blk = wr_addr[`FPM_BLOCK_LSB +: `FPM_BLOCK_W];
    end

    // Protection: boot block follows the lock pin, all lower blocks write protect
    always @* begin
        if (blk == `FPM_TOP_BLOCK)
            protect = !tbl_s;
        else
            protect = !wp_s;
    end

    // Write start: falling write enable with output enable high, or an addressed hub write;
    // output enable low inhibits parallel writes so a read never turns into a program
    always @* begin
        if (cfg_reg)
            wr_fire = we_prev_reg && !we_s && oe_s;
        else
            wr_fire = hub_write_req_i && id_match_o;
    end

    // Configuration follows the pin while initialize or reset is low and is taken once more
    // on release; the mode flags stay off until that sample, so settling levels never show
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_reg <= 1'b0;
            cfg_valid_reg <= 1'b0;
        end else if (!rst_lvl_s) begin
            cfg_reg <= cfg_s;
            cfg_valid_reg <= 1'b0;
        end else if (!cfg_valid_reg) begin
            cfg_reg <= cfg_s;
            cfg_valid_reg <= 1'b1;
        end
    end

    // Previous write enable level for edge detection; idles high like the pin
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            we_prev_reg <= 1'b1;
        end else begin
            we_prev_reg <= we_s;
        end
    end

    // Address halves load by select level while in parallel mode
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            row_reg <= {PW{1'b0}};
            col_reg <= {PW{1'b0}};
        end else if (cfg_reg) begin
            if (rc_s)
                row_reg <= addr_s;
            else
                col_reg <= addr_s;
        end
    end

    // Mode flags, combined internal reset and identity compare
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            parallel_program_mode_o <= 1'b0;
            hub_serial_mode_o <= 1'b0;
            int_reset_n_o <= 1'b0;
            id_match_o <= 1'b0;
        end else begin
            parallel_program_mode_o <= cfg_valid_reg && cfg_reg;
            hub_serial_mode_o <= cfg_valid_reg && !cfg_reg;
            int_reset_n_o <= cfg_reg ? rstn_s : rst_lvl_s;
            id_match_o <= (hub_target_id_i == strap_identity_inputs_i);
        end
    end

    // Data drivers on only while output enable is low in parallel mode
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            parallel_data_pins_o <= {DW{1'b0}};
            parallel_data_pins_oe_o <= 1'b0;
        end else begin
            parallel_data_pins_oe_o <= cfg_reg && !oe_s && int_reset_n_o;
            parallel_data_pins_o <= read_data_i;
        end
    end

    // Address and data captured on the write in the same cycle as one result pulse;
    // the latched values stand until the next write whatever the pins do
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            latched_addr_o <= {AW{1'b0}};
            latched_data_o <= {DW{1'b0}};
            write_start_o <= 1'b0;
            write_refused_o <= 1'b0;
        end else begin
            write_start_o <= 1'b0;
            write_refused_o <= 1'b0;
            if (write_go) begin
                latched_addr_o <= wr_addr;
                latched_data_o <= cfg_reg ? data_s : read_data_i;
                write_start_o <= !protect;
                write_refused_o <= protect;
            end
        end
    end
endmodule

// ===== fpm_pin_ctrl_properties.sv
`timescale 1ns/100ps
module fpm_pin_props (
    input wire ref_clk_i,
    input wire rst_b_i,
    input wire top_block_lock_n_i,
    input wire write_protect_n_i,
    input wire output_enable_n_i,
    input wire write_enable_n_i,
    input wire parallel_data_pins_oe_o,
    input wire parallel_program_mode_o,
    input wire hub_serial_mode_o,
    input wire [21:0] latched_addr_o,
    input wire write_start_o,
    input wire write_refused_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Short names for the pulses and the block decode
    wire st = write_start_o;
    wire rf = write_refused_o;
    wire top = latched_addr_o[19:16] == 4'hF;
    a_mode_one_hot: assert property (!(parallel_program_mode_o && hub_serial_mode_o))
        else $error("two modes");
    a_oe_release: assert property ($past(output_enable_n_i, 3) &&
        $past(output_enable_n_i, 4) |-> !parallel_data_pins_oe_o) else $error("driven");
    a_we_needed: assert property (st && parallel_program_mode_o |->
        !$past(write_enable_n_i, 2)) else $error("no write enable");
    a_start_gap: assert property (st |=> !st && !rf) else $error("start gap");
    a_refuse_gap: assert property (rf |=> !st && !rf) else $error("refuse gap");
    a_pulse_excl: assert property (!(st && rf)) else $error("both pulses");
    a_top_lock: assert property (st && top |-> $past(top_block_lock_n_i, 4))
        else $error("boot written");
    a_wp_lower: assert property (st && !top |-> $past(write_protect_n_i, 4))
        else $error("lower written");
endmodule
bind fpm_flash_pin_ctrl fpm_pin_props u_fpm_pin_props (.*);

// ===== fpm_prog_model.sv
`timescale 1ns/100ps
module fpm_prog_model (
    input wire ref_clk_i,
    output reg rc_o,
    output reg [10:0] addr_o,
    output reg [7:0] data_o,
    output reg we_n_o
);
    initial {rc_o, addr_o, data_o, we_n_o} = 21'h000001;
    // Row, column, write pulse, then scrambled pins; each stands 4 clocks
    task write(input [21:0] a, input [7:0] d);
        integer k;
        for (k = 0; k < 4; k = k + 1) begin
            {rc_o, addr_o, data_o, we_n_o} <= k == 0 ? {1'b1, a[21:11], ~d, 1'b1} :
                k == 3 ? {1'b0, ~a[10:0], ~d, 1'b1} : {1'b0, a[10:0], d, k[0]};
            repeat (4) @(posedge ref_clk_i);
        end
    endtask
endmodule

// ===== fpm_regs.vh
`ifndef FPM_REGS_VH
`define FPM_REGS_VH
// Address and data widths, block decode and boot identity
`define FPM_PIN_AW 11
`define FPM_ADDR_AW 22
`define FPM_BLOCK_LSB 16
`define FPM_BLOCK_W 4
`define FPM_TOP_BLOCK 4'hF
`define FPM_BOOT_ID 4'h0
`define FPM_DATA_W 8
`endif

// ===== fpm_sync.v
`timescale 1ns/100ps
// Two-flop synchroniser for a bus of pin levels
module fpm_sync #(
    parameter W = 1
) (
    input wire ref_clk_i,
    input wire rst_b_i,
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);
    reg [W-1:0] meta_reg;

    // First stage feeds only the second
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= {W{1'b0}};
            q_o <= {W{1'b0}};
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

// ===== testbench.sv
`timescale 1ns/100ps
module testbench;
    reg ref_clk_i, rst_b_i, interface_config_select_i, init_n_i, reset_n_i, hub_write_req_i;
    reg top_block_lock_n_i, write_protect_n_i, output_enable_n_i;
    reg [3:0] strap_identity_inputs_i, hub_target_id_i;
    reg [7:0] read_data_i, d;
    reg [21:0] hub_addr_i, a;
    reg [30:0] e, q[$];
    wire row_col_sel_i, write_enable_n_i, parallel_data_pins_oe_o, parallel_program_mode_o;
    wire hub_serial_mode_o, int_reset_n_o, id_match_o, write_start_o, write_refused_o;
    wire [10:0] muxed_address_pins_i;
    wire [7:0] pd, parallel_data_pins_i, parallel_data_pins_o, latched_data_o;
    wire [21:0] latched_addr_o;
    integer bad_count, num_checks, i;
    // Device drivers win the data wire while enabled
    assign parallel_data_pins_i = parallel_data_pins_oe_o ? parallel_data_pins_o : pd;
    fpm_flash_pin_ctrl u_fpm_flash_pin_ctrl (.*);
    fpm_prog_model u_fpm_prog_model (.ref_clk_i(ref_clk_i), .rc_o(row_col_sel_i),
        .addr_o(muxed_address_pins_i), .data_o(pd), .we_n_o(write_enable_n_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task chk(input string n, input [31:0] x, input [31:0] y);
        num_checks++;
        if (x !== y) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", n, x, y);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Each result pulse takes the oldest note
    always @(posedge ref_clk_i) if (write_start_o || write_refused_o) begin
        e = q.pop_front();
        chk("refused", e[30], write_refused_o);
        if (write_start_o) chk("addr", e[29:8], latched_addr_o);
        if (write_start_o) chk("data", e[7:0], latched_data_o);
    end
    // Watchdog
    initial begin
        #100000 bad_count++;
        close_out;
    end
    initial begin
        {bad_count, num_checks} = 0;
        void'($urandom(83658));
        {rst_b_i, hub_write_req_i, hub_addr_i, read_data_i, strap_identity_inputs_i} = 0;
        {hub_target_id_i, top_block_lock_n_i, write_protect_n_i} = 0;
        {interface_config_select_i, init_n_i, reset_n_i, output_enable_n_i} = 4'hF;
        repeat (5) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        chk("mode", 1, parallel_program_mode_o);
        chk("boot id", 1, id_match_o);
        for (i = 0; i < 4; i++) begin
            a = 22'($urandom);
            d = 8'($urandom);
            a[19:16] = i[0] ? 4'hF : 4'($urandom_range(14));
            {top_block_lock_n_i, write_protect_n_i} <= i[0] ? {i[1], 1'b1} : {1'b1, i[1]};
            q.push_back({~i[1], a, d});
            u_fpm_prog_model.write(a, d);
        end
        read_data_i <= 8'($urandom);
        output_enable_n_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        chk("drive", {1'b1, read_data_i}, {parallel_data_pins_oe_o, parallel_data_pins_o});
        {output_enable_n_i, interface_config_select_i, reset_n_i} <= 3'h4;
        repeat (4) @(posedge ref_clk_i);
        chk("rst", 0, int_reset_n_o);
        reset_n_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        chk("hub", 1, hub_serial_mode_o);
        for (i = 0; i < 2; i++) begin
            d = 8'($urandom);
            strap_identity_inputs_i <= d[3:0];
            hub_target_id_i <= i[0] ? d[3:0] : ~d[3:0];
            init_n_i <= i[0];
            repeat (5) @(posedge ref_clk_i);
            chk("id", i, id_match_o);
            chk("init", i, int_reset_n_o);
        end
        close_out;
    end
endmodule
